// file: verilog/sdram_mux_pkg.sv
// Package for the SDRAM DMA address and command multiplexer.
// Assumes a single 25 MHz clock domain and an Avalon-MM register master.
package sdram_mux_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one aligned word each).
   // ----------------------------------------------------------------
   localparam int          REG_AW        = 4;        // Byte address width of the slave.
   localparam logic [3:0]  MEMCTL_OFF    = 4'h0;     // Memory controller control register.
   localparam logic [3:0]  SYSCTL_OFF    = 4'h4;     // System control register.
   localparam logic [3:0]  STATUS_OFF    = 4'h8;     // Block status register.
   localparam logic [3:0]  CHIPID_OFF    = 4'hc;     // Chip identity register.

   // ----------------------------------------------------------------
   // Field layout and reset values.
   // ----------------------------------------------------------------
   localparam int          MEMSEL_BIT    = 0;        // 1 = SDRAM attached, 0 = EDO DRAM.
   localparam int          WCODE_LSB     = 2;        // Row-address-width code, bits [4:2].
   localparam int          WCODE_W       = 3;        // Width of the row-address-width code.
   localparam int          DIRSTB_BIT    = 13;       // Direction strobe enable.
   localparam int          LEAK_BIT      = 0;        // Status: leaked column bit seen, write 1 to clear.
   localparam int          BUSY_BIT      = 1;        // Status: access in progress.
   localparam int          STATE_LSB     = 4;        // Status: current sequencer state.
   localparam logic        MEMSEL_RST    = 1'b1;     // SDRAM is assumed after reset.
   localparam logic [2:0]  WCODE_RST     = 3'h0;     // Narrowest organisation after reset.
   localparam logic [31:0] CHIP_ID       = 32'h0000_0a5e; // Arbitrary identity value.

   // ----------------------------------------------------------------
   // Width codes: code = (row + bank address bits) - 10.
   // ----------------------------------------------------------------
   localparam logic [2:0]  WC_10         = 3'h0;
   localparam logic [2:0]  WC_11         = 3'h1;
   localparam logic [2:0]  WC_12         = 3'h2;
   localparam logic [2:0]  WC_13         = 3'h3;
   localparam int          SEL_A20       = 20;       // System bit for widths 10, 14, 15.
   localparam int          SEL_A23       = 23;       // System bit for width 11.
   localparam int          SEL_A24       = 24;       // System bit for width 12.
   localparam int          SEL_A25       = 25;       // System bit for width 13.

   // ----------------------------------------------------------------
   // SDRAM address layout and commands {cs_n, ras_n, cas_n, we_n}.
   // ----------------------------------------------------------------
   localparam int          DMA_AW        = 26;       // DMA byte address width.
   localparam int          SA_W          = 13;       // SDRAM address pins.
   localparam int          A10_POS       = 10;       // Auto-precharge pin position.
   localparam int          COL_LSB       = 2;        // Column word address starts here.
   localparam int          COL_W         = 9;        // Column bits.
   localparam int          BA_LSB        = 11;       // Internal bank bits.
   localparam int          BA_W          = 2;
   localparam int          ROW_LSB       = 13;       // Row bits.
   localparam logic [3:0]  CMD_NOP       = 4'h7;
   localparam logic [3:0]  CMD_ACT       = 4'h3;
   localparam logic [3:0]  CMD_READ      = 4'h5;
   localparam logic [3:0]  CMD_WRITE     = 4'h4;
   localparam logic [3:0]  CMD_PRE       = 4'h2;
   localparam int          CNT_W         = 4;        // Width of the wait counter.

   // Sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RCD  = 3'b001,
      ST_COL  = 3'b010,
      ST_DATA = 3'b011,
      ST_PRE  = 3'b100,
      ST_RP   = 3'b101
   } seq_state_t;

endpackage : sdram_mux_pkg

// file: verilog/sdram_dma_address_mux.sv
// Address and command multiplexer for DMA accesses to SDRAM or EDO DRAM.
// Assumes a DMA engine on ref_clk that holds its request until done, SDRAM
// running from the same clock, and an Avalon-MM master for the registers.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps

// Notes on behaviour
// - Rows closed only by explicit PRECHARGE when SDRAM is selected; in EDO mode a high A10 bit can auto-precharge.
// - A10 held low at SDRAM column time.
// - EDO address routing to A10 gated for SDRAM.
// - Width code in bits [4:2] forms addresses.
// - Widths 10, 14, 15 route A20.
// - Widths 11, 12, 13 route A23, A24, A25.
// - Active-low transceiver strobe enabled by bit 13.
// - Strobe low on SDRAM DMA reads, else high.
module sdram_dma_address_mux
   import sdram_mux_pkg::*;
#(
   parameter int RCD_CYC = 2,                  // Activate to column command, in cycles.
   parameter int CL_CYC  = 2,                  // Read latency, in cycles.
   parameter int WR_CYC  = 2,                  // Write recovery before precharge, in cycles.
   parameter int RP_CYC  = 2                   // Precharge to next activate, in cycles.
) (
   input  wire logic                ref_clk,      // 25 MHz clock.
   input  wire logic                arst_n,       // Asynchronous reset, active low.
   input  wire logic [REG_AW-1:0]   address,      // Avalon byte address.
   input  wire logic                read,         // Avalon read request.
   input  wire logic                write,        // Avalon write request.
   input  wire logic [31:0]         writedata,    // Avalon write data.
   input  wire logic [3:0]          byteenable,   // Avalon byte lanes.
   output logic      [31:0]         readdata,     // Avalon read data.
   output logic                     waitrequest,  // Avalon stall.
   input  wire logic                dmaReq,       // DMA access request, held until dmaDone.
   input  wire logic                dmaWrite,     // 1 = write, 0 = read.
   input  wire logic [DMA_AW-1:0]   dmaAddr,      // DMA byte address relative to bank base.
   output logic                     dmaDone,      // One-cycle pulse when the access ends.
   output logic                     sdramCsN,     // SDRAM chip select, active low.
   output logic                     sdramRasN,    // Row strobe, active low.
   output logic                     sdramCasN,    // Column strobe, active low.
   output logic                     sdramWeN,     // Write enable, active low.
   output logic      [SA_W-1:0]     sdramAddr,    // Multiplexed address pins.
   output logic      [BA_W-1:0]     sdramBa,      // Internal bank select.
   output logic                     xcvrDirStrobe_n // Transceiver direction strobe, active low.
);

   // ----------------------------------------------------------------
   // State of the block.
   // ----------------------------------------------------------------
   typedef struct packed {
      seq_state_t          st;        // Sequencer state.
      logic [CNT_W-1:0]    cnt;       // Wait counter.
      logic [DMA_AW-1:0]   addr;      // Latched DMA address.
      logic                wr;        // Latched direction.
      logic [WCODE_W-1:0]  wcode;     // Row-address-width code.
      logic                sdramSel;  // Attached memory is SDRAM.
      logic                dirEn;     // Direction strobe enable.
      logic                leakSeen;  // A high bit would have leaked onto A10.
      logic [3:0]          cmd;       // Registered command pins.
      logic [SA_W-1:0]     sa;        // Registered address pins.
      logic [BA_W-1:0]     ba;        // Registered bank pins.
      logic                dirN;      // Registered strobe.
      logic                done;      // Registered done pulse.
      logic                ack;       // Bus access answered this cycle.
      logic [31:0]         rdata;     // Registered read data.
   } regs_t;

   regs_t q;                           // Current state.
   regs_t d;                           // Next state.

   // Wait counts cut to the counter width.
   localparam logic [CNT_W-1:0] RCD_N = CNT_W'(RCD_CYC - 1);
   localparam logic [CNT_W-1:0] CL_N  = CNT_W'(CL_CYC);
   localparam logic [CNT_W-1:0] WR_N  = CNT_W'(WR_CYC);
   localparam logic [CNT_W-1:0] RP_N  = CNT_W'(RP_CYC - 1);

   logic       busReq;                 // A bus access is pending.
   logic       leakBit;                // System bit that the EDO path routes to A10.
   logic [31:0] readMux;               // Read data selected by address.

   // ----------------------------------------------------------------
   // Leaked bit selection from the width code.
   // ----------------------------------------------------------------
   // The code picks the high-order system bit that the EDO path puts on A10.
   always_comb begin
      unique case (q.wcode)
         WC_11:   leakBit = q.addr[SEL_A23];
         WC_12:   leakBit = q.addr[SEL_A24];
         WC_13:   leakBit = q.addr[SEL_A25];
         default: leakBit = q.addr[SEL_A20];
      endcase
   end

   // ----------------------------------------------------------------
   // Register read multiplexer.
   // ----------------------------------------------------------------
   // Unmapped offsets and reserved bits read as zero.
   always_comb begin
      readMux = 32'h0000_0000;
      unique case (address)
         MEMCTL_OFF: begin
            readMux[MEMSEL_BIT] = q.sdramSel;
            readMux[WCODE_LSB +: WCODE_W] = q.wcode;
         end
         SYSCTL_OFF: readMux[DIRSTB_BIT] = q.dirEn;
         STATUS_OFF: begin
            readMux[LEAK_BIT] = q.leakSeen;
            readMux[BUSY_BIT] = (q.st != ST_IDLE);
            readMux[STATE_LSB +: 3] = q.st;
         end
         CHIPID_OFF: readMux = CHIP_ID;
         default:    readMux = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------
   // Bus slave, sequencer and pin drive all decide here.
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.cmd  = CMD_NOP;
      busReq = (read | write) & ~q.ack;
      // Every access is answered on the first edge after it rises.
      d.ack = busReq;
      if (busReq & read) begin
         d.rdata = readMux;
      end
      // Register writes with byte lanes.
      if (busReq & write) begin
         unique case (address)
            MEMCTL_OFF: begin
               if (byteenable[0]) begin
                  d.sdramSel = writedata[MEMSEL_BIT];
                  d.wcode    = writedata[WCODE_LSB +: WCODE_W];
               end
            end
            SYSCTL_OFF: begin
               if (byteenable[1]) begin
                  d.dirEn = writedata[DIRSTB_BIT];
               end
            end
            STATUS_OFF: begin
               if (byteenable[0] & writedata[LEAK_BIT]) begin
                  d.leakSeen = 1'b0;
               end
            end
            default: begin
               // Writes to read-only or unmapped words are dropped.
            end
         endcase
      end
      // Sequencer.
      unique case (q.st)
         ST_IDLE: begin
            // q.done is always low by ST_IDLE, so a request still held across dmaDone is taken again.
            if (dmaReq & ~q.done) begin
               d.addr = dmaAddr;
               d.wr   = dmaWrite;
               d.cmd  = CMD_ACT;
               d.sa   = dmaAddr[ROW_LSB +: SA_W];
               d.ba   = dmaAddr[BA_LSB +: BA_W];
               d.cnt  = RCD_N;
               d.st   = ST_RCD;
            end
         end
         ST_RCD: begin
            if (q.cnt != '0) begin
               d.cnt = q.cnt - 1'b1;
            end else begin
               d.st = ST_COL;
            end
         end
         ST_COL: begin
            // Column phase; A10 stays low for SDRAM, carries the bit for EDO.
            d.cmd = q.wr ? CMD_WRITE : CMD_READ;
            d.sa  = '0;
            d.sa[COL_W-1:0] = q.addr[COL_LSB +: COL_W];
            d.sa[A10_POS] = q.sdramSel ? 1'b0 : leakBit;
            if (leakBit) begin
               d.leakSeen = 1'b1;                                 // Set wins over clear.
            end
            d.dirN = ~(q.dirEn & ~q.wr & q.sdramSel);
            d.cnt  = q.wr ? WR_N : CL_N;
            d.st   = ST_DATA;
         end
         ST_DATA: begin
            if (q.cnt != '0) begin
               d.cnt = q.cnt - 1'b1;
            end else begin
               d.dirN = 1'b1;
               d.st   = ST_PRE;
            end
         end
         ST_PRE: begin
            // Explicit precharge closes the row once the burst is over.
            d.cmd  = CMD_PRE;
            d.sa   = '0;
            d.ba   = q.addr[BA_LSB +: BA_W];
            d.done = 1'b1;
            d.cnt  = RP_N;
            d.st   = ST_RP;
         end
         ST_RP: begin
            if (q.cnt != '0) begin
               d.cnt = q.cnt - 1'b1;
            end else begin
               d.st = ST_IDLE;
            end
         end
         default: d.st = ST_IDLE;
      endcase
      // Strobe is forced high whenever the enable is off.
      if (~q.dirEn) begin
         d.dirN = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------
   // All control state takes constants under reset.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         q          <= '0;
         q.st       <= ST_IDLE;
         q.wcode    <= WCODE_RST;
         q.sdramSel <= MEMSEL_RST;
         q.cmd      <= CMD_NOP;
         q.dirN     <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   assign waitrequest     = busReq;
   assign readdata        = q.rdata;
   assign dmaDone         = q.done;
   assign sdramCsN        = q.cmd[3];
   assign sdramRasN       = q.cmd[2];
   assign sdramCasN       = q.cmd[1];
   assign sdramWeN        = q.cmd[0];
   assign sdramAddr       = q.sa;
   assign sdramBa         = q.ba;
   assign xcvrDirStrobe_n = q.dirN;

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   logic colCmd;                       // A column command is on the pins.
   assign colCmd = (q.cmd == CMD_READ) || (q.cmd == CMD_WRITE);

   // Every column command is followed by an explicit precharge.
   a_explicit_precharge: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      colCmd |-> ##[1:16] (q.cmd == CMD_PRE))
      else $error("column command not followed by precharge");

   // SDRAM column commands never carry A10 high.
   a_a10_low_sdram: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (colCmd && q.sdramSel) |-> (q.sa[A10_POS] == 1'b0))
      else $error("A10 high at SDRAM column time");

   // EDO column phase carries the selected bit on A10.
   a_edo_routing: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (q.st == ST_COL && !q.sdramSel && !(read | write)) |=> (q.sa[A10_POS] == $past(leakBit)))
      else $error("EDO A10 routing wrong");

   // A width code write is seen in the register after the answer.
   a_width_code: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (write && !q.ack && address == MEMCTL_OFF && byteenable[0])
      |=> (q.wcode == $past(writedata[WCODE_LSB +: WCODE_W])))
      else $error("width code not stored");

   // Widths 10, 14 and 15 select A20.
   a_a20_select: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (q.wcode == WC_10 || q.wcode > WC_13) |-> (leakBit == q.addr[SEL_A20]))
      else $error("A20 not selected");

   // Widths 11, 12 and 13 select A23, A24 and A25.
   a_high_select: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (q.wcode == WC_11 |-> leakBit == q.addr[SEL_A23]) and
      (q.wcode == WC_12 |-> leakBit == q.addr[SEL_A24]) and
      (q.wcode == WC_13 |-> leakBit == q.addr[SEL_A25]))
      else $error("high address bit not selected");

   // Enabled strobe goes low with an SDRAM read command.
   a_strobe_read: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (q.cmd == CMD_READ && q.sdramSel && $past(q.dirEn)) |-> !xcvrDirStrobe_n)
      else $error("strobe not low on read");

   // Disabled strobe stays high.
   a_strobe_idle: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      $past(!q.dirEn) |-> xcvrDirStrobe_n)
      else $error("strobe low while disabled");

endmodule : sdram_dma_address_mux

// file: verif/sdram_model.sv
// Behavioural SDRAM device watching the command and address pins.
// Assumes registered commands on ref_clk, sampled at its rising edge.
`timescale 1ns/1ps
module sdram_model
   import sdram_mux_pkg::*;
(
   input  wire logic            ref_clk,  // Memory clock.
   input  wire logic            arst_n,   // Reset, active low.
   input  wire logic [3:0]      cmd,      // Command {cs_n, ras_n, cas_n, we_n}.
   input  wire logic [SA_W-1:0] addr,     // Address pins.
   output int                   actCount, // Activates seen.
   output int                   colCount, // Column commands seen.
   output int                   preCount, // Explicit precharges seen.
   output int                   apCount,  // Column commands asking for auto-precharge.
   output int                   seqErr    // Commands given in an illegal order.
);
   logic rowOpen;                         // A row is open in the device.

   // ----------------------------------------------------------------
   // Command decode.
   // ----------------------------------------------------------------
   // A column command with A10 high starts an internal precharge, so the
   // row closes under a running burst; it is counted so the bench sees it.
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         {actCount, colCount, preCount, apCount, seqErr} <= '0;
         rowOpen <= 1'b0;
      end else begin
         case (cmd)
            CMD_ACT: begin
               actCount <= actCount + 1;
               seqErr   <= seqErr + int'(rowOpen);
               rowOpen  <= 1'b1;
            end
            CMD_READ, CMD_WRITE: begin
               colCount <= colCount + 1;
               seqErr   <= seqErr + int'(!rowOpen);
               apCount  <= apCount + int'(addr[A10_POS]);
               rowOpen  <= rowOpen & !addr[A10_POS];
            end
            CMD_PRE: begin
               preCount <= preCount + 1;
               rowOpen  <= 1'b0;
            end
            default: begin
               rowOpen <= rowOpen;                        // NOP leaves the bank alone.
            end
         endcase
      end
   end
endmodule : sdram_model

// file: verif/testbench.sv
// Self-checking bench for the SDRAM DMA address multiplexer.
// Assumes the package constants and the SDRAM model beside this file.
`timescale 1ns/1ps
module testbench;
   import sdram_mux_pkg::*;
   logic              ref_clk, arst_n, read, write, dmaReq, dmaWrite;
   logic              waitrequest, dmaDone, sdramCsN, sdramRasN, sdramCasN, sdramWeN, xcvrDirStrobe_n;
   logic [REG_AW-1:0] address;    // Register address.
   logic [31:0]       writedata;  // Register write data.
   logic [31:0]       readdata;   // Register read data.
   logic [3:0]        byteenable; // Register byte lanes.
   logic [DMA_AW-1:0] dmaAddr;    // DMA byte address.
   logic [SA_W-1:0]   sdramAddr;  // SDRAM address pins.
   logic [BA_W-1:0]   sdramBa;    // SDRAM bank pins.
   logic [3:0]        cmd;        // Command pins gathered.
   int                bad_count, n_compared, cycles, actCount, colCount, preCount, apCount, seqErr;
   int                expAct, expCol, expAp; // Counts predicted by the bench.
   localparam int     CLAT = 2;   // Read latency given to the instance, in cycles.

   assign cmd = {sdramCsN, sdramRasN, sdramCasN, sdramWeN};

   sdram_dma_address_mux #(.RCD_CYC(2), .CL_CYC(CLAT), .WR_CYC(2), .RP_CYC(2)) uut (
      .ref_clk(ref_clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .dmaReq(dmaReq), .dmaWrite(dmaWrite), .dmaAddr(dmaAddr), .dmaDone(dmaDone),
      .sdramCsN(sdramCsN), .sdramRasN(sdramRasN), .sdramCasN(sdramCasN), .sdramWeN(sdramWeN),
      .sdramAddr(sdramAddr), .sdramBa(sdramBa), .xcvrDirStrobe_n(xcvrDirStrobe_n));

   sdram_model mem (.ref_clk(ref_clk), .arst_n(arst_n), .cmd(cmd), .addr(sdramAddr),
      .actCount(actCount), .colCount(colCount), .preCount(preCount), .apCount(apCount), .seqErr(seqErr));

   // ----------------------------------------------------------------
   // Clock and watchdog.
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // A hung handshake is cut short well beyond the expected run length.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Compare tasks, verdict and stimulus helpers.
   // ----------------------------------------------------------------
   task automatic checkReg(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : checkReg

   task automatic checkPin(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : checkPin

   task automatic results();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results

   // Shifts the stimulus register one step.
   function automatic logic [31:0] lfsrNext(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsrNext

   // System address bit that reaches A10 for a width code.
   function automatic int selBit(input int code);
      case (code)
         1: return 23;
         2: return 24;
         3: return 25;
         default: return 20;
      endcase
   endfunction : selBit

   // Avalon write: held until waitrequest is sampled low.
   task automatic busWrite(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      address    <= a;
      writedata  <= d;
      byteenable <= be;
      write      <= 1'b1;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask : busWrite

   // Avalon read: data taken at the edge where waitrequest is low.
   task automatic busRead(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      address <= a;
      read    <= 1'b1;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
   endtask : busRead

   // One DMA access, checked cycle by cycle against the predicted pins.
   task automatic doDma(input int wr, input logic [DMA_AW-1:0] a, input int edo, input int en, input int sb);
      int          col, done, stb, age;
      logic [15:0] colAddr;
      colAddr = 16'((a >> 2) & 511) | 16'((edo != 0 ? int'(a[sb]) : 0) << 10);
      col    = 0;
      done   = 0;
      age    = 0;
      @(posedge ref_clk);
      dmaReq   <= 1'b1;
      dmaWrite <= wr[0];
      dmaAddr  <= a;
      for (int n = 0; n < 40 && done == 0; n++) begin
         @(negedge ref_clk);
         // Cycles since the column command, which is cycle zero.
         if (col > 0) begin
            age++;
         end
         if (cmd == CMD_ACT) begin
            checkPin("row", 16'(a >> 13), 16'(sdramAddr));
            checkPin("bank", 16'(a[12:11]), 16'(sdramBa));
         end
         if (cmd == CMD_READ || cmd == CMD_WRITE) begin
            col++;
            checkPin("column cmd", 16'(wr != 0 ? CMD_WRITE : CMD_READ), 16'(cmd));
            checkPin("column addr", colAddr, 16'(sdramAddr));
         end
         // The strobe is low from the read command through the read latency only.
         stb = (col > 0 && age <= CLAT && wr == 0 && edo == 0 && en != 0) ? 0 : 1;
         checkPin("strobe", 16'(stb), 16'(xcvrDirStrobe_n));
         if (dmaDone === 1'b1) begin
            done = 1;
            checkPin("close cmd", 16'(CMD_PRE), 16'(cmd));
         end
      end
      checkPin("column count", 16'h1, 16'(col));
      checkPin("done seen", 16'h1, 16'(done));
      expAct++;
      expCol++;
      expAp += (edo != 0) ? int'(a[sb]) : 0;
      @(posedge ref_clk);
      dmaReq <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : doDma

   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      logic [31:0]       seed, d, mc;
      logic [DMA_AW-1:0] a;
      int                sb;
      {arst_n, read, write, dmaReq, dmaWrite, address, writedata, byteenable, dmaAddr} = '0;
      {bad_count, n_compared, cycles, expAct, expCol, expAp} = '0;
      seed = 32'h1f;
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      busRead(MEMCTL_OFF, d);
      checkReg("memctl reset", 32'(WCODE_RST) << WCODE_LSB | 32'(MEMSEL_RST), d);
      busRead(SYSCTL_OFF, d);
      checkReg("sysctl reset", 32'h0, d);
      busRead(CHIPID_OFF, d);
      checkReg("chip id", CHIP_ID, d);
      busRead(4'h2, d);
      checkReg("unmapped read", 32'h0, d);
      busWrite(4'h6, 32'hffffffff, 4'hf);
      busWrite(SYSCTL_OFF, 32'h2000, 4'h1);
      busRead(SYSCTL_OFF, d);
      checkReg("sysctl lane gate", 32'h0, d);
      // SDRAM first, then EDO; every width code, both directions.
      for (int edo = 0; edo < 2; edo++) begin
         for (int code = 0; code < 8; code++) begin
            for (int wr = 0; wr < 2; wr++) begin
               seed = lfsrNext(seed);
               sb   = selBit(code);
               busWrite(SYSCTL_OFF, 32'(seed[5]) << DIRSTB_BIT, 4'hf);
               mc = 32'(code) << WCODE_LSB | 32'(edo == 0);
               busWrite(MEMCTL_OFF, mc, 4'hf);
               busRead(MEMCTL_OFF, d);
               checkReg("memctl", mc, d);
               a     = seed[25:0] ^ 26'(seed[31:8]);
               a[sb] = seed[7];
               doDma(wr, a, edo, int'(seed[5]), sb);
               if (edo == 0) begin
                  busRead(STATUS_OFF, d);
                  checkReg("leak flag", 32'(a[sb]), d);
                  busWrite(STATUS_OFF, 32'h1, 4'h1);
               end
            end
         end
      end
      checkPin("activates", 16'(expAct), 16'(actCount));
      checkPin("column cmds", 16'(expCol), 16'(colCount));
      checkPin("precharges", 16'(expAct), 16'(preCount));
      checkPin("auto precharge", 16'(expAp), 16'(apCount));
      checkPin("order errors", 16'h0, 16'(seqErr));
      results();
   end
endmodule : testbench
